// ===== rtl/sciv_regs.svh
// Offsets, field positions and reset values of the slot control initial value bank.
`ifndef SCIV_REGS_SVH
`define SCIV_REGS_SVH
`define SCIV_INIT_OFS 12'h420
`define SCIV_LIVE_OFS 12'h424
`define SCIV_CMD_DONE_BIT 4
`define SCIV_HOTPLUG_BIT 5
`define SCIV_ATTN_LSB 6
`define SCIV_PWR_IND_LSB 8
`define SCIV_PWR_CTRL_BIT 10
`define SCIV_LINK_CHG_BIT 12
`define SCIV_ATTN_RST 2'h3
`define SCIV_PWR_IND_RST 2'h1
`define SCIV_INIT_RST 16'h01C0
`define SCIV_RW_MASK 16'h17FF
`endif

// ===== rtl/sciv_pkg.sv
// Types shared by the slot control initial value bank.
package sciv_pkg;
    typedef logic [15:0] sciv_word_t;
    typedef enum logic {sciv_idle, sciv_access} sciv_phase_t;
endpackage : sciv_pkg

// ===== rtl/sciv_slot_init.sv
// Slot control initial value register with its live slot control copy and APB slave.
`timescale 1ns/10ps
`include "sciv_regs.svh"
//
// Operation
// - Bit 4 seeds command-complete interrupt enable
// - Bit 5 seeds hot-plug interrupt enable
// - Bits 7:6 seed attention indicator, default 3
// - Bits 9:8 seed power indicator, default 1
// - Bit 10 seeds power controller, default 0
// - Bit 12 seeds link-active change enable
// - Writes reach live slot control at once
// - Partition reset leaves capability and init untouched
// - Partition reset reloads live fields from register
// - Register decoded at offset 0x420
module sciv_slot_init #(
    parameter int ADDR_W = 12
) (
    // APB clock and fundamental reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Port side: partition reset pulse and slot or hot-plug capability enable.
    input wire logic part_rst,
    input wire logic cap_en,
    // Standard slot control write path from configuration space.
    input wire logic cfg_wr,
    input wire logic [15:0] cfg_wdata,
    // Live slot control fields.
    output sciv_pkg::sciv_word_t live_slot_control
);
    import sciv_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************

    // Merges a write into a 16-bit word under the two low byte strobes.
    function automatic sciv_word_t merge_wr(sciv_word_t old, logic [31:0] d, logic [3:0] s);
        sciv_word_t r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[15:8] = d[15:8];
        end
        return r & `SCIV_RW_MASK;
    endfunction : merge_wr

    // Word address match, ignoring the byte offset bits.
    function automatic logic hit(logic [ADDR_W-1:0] a, logic [11:0] ofs);
        return a[ADDR_W-1:2] == (ADDR_W-2)'(ofs >> 2);
    endfunction : hit

    // ************************************************************
    // APB phase tracking
    // ************************************************************

    sciv_phase_t phase_reg, phase_next;
    logic pready_next, pslverr_next;
    logic [31:0] prdata_next;
    sciv_word_t init_reg, init_next, live_reg, live_next;
    logic cap_en_reg, cap_en_next;
    logic wr_fire, init_wr, cap_rise;

    // A transfer completes in the first access cycle, so writes land one edge after setup.
    assign wr_fire = psel && penable && pwrite && pready;
    assign init_wr = wr_fire && hit(paddr, `SCIV_INIT_OFS);
    assign cap_rise = cap_en && !cap_en_reg;

    // Next phase and registered answer; read data is captured in the setup cycle.
    always_comb begin
        phase_next = sciv_idle;
        pready_next = 1'b0;
        pslverr_next = 1'b0;
        prdata_next = 32'h0000_0000;
        case (phase_reg)
            sciv_idle: begin
                if (psel && !penable) begin
                    phase_next = sciv_access;
                    pready_next = 1'b1;
                    if (hit(paddr, `SCIV_INIT_OFS)) begin
                        prdata_next = pwrite ? 32'h0000_0000 : {16'h0000, init_reg};
                    end else if (hit(paddr, `SCIV_LIVE_OFS)) begin
                        prdata_next = pwrite ? 32'h0000_0000 : {16'h0000, live_reg};
                        pslverr_next = pwrite; // Live copy is read-only here.
                    end else begin
                        pslverr_next = 1'b1;
                    end
                end
            end
            sciv_access: begin
                phase_next = sciv_idle;
            end
            default: begin
                phase_next = sciv_idle;
            end
        endcase
    end

    // Bus answer registers; all three outputs come straight from flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_reg <= sciv_idle;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            phase_reg <= phase_next;
            pready <= pready_next;
            pslverr <= pslverr_next;
            prdata <= prdata_next;
        end
    end

    // ************************************************************
    // Initial value and live slot control
    // ************************************************************

    // The initial value only changes on an APB write. Partition reset does not
    // touch it, which is what lets software choose the post-reset slot state.
    always_comb begin
        init_next = init_reg;
        if (init_wr) begin
            init_next = merge_wr(init_reg, pwdata, pstrb);
        end
    end

    // Live fields: an init write wins, then reload, then the standard write path.
    // Giving the init write priority keeps the immediate-effect promise exact.
    always_comb begin
        cap_en_next = cap_en;
        live_next = live_reg;
        if (init_wr) begin
            live_next = init_next;
        end else if (part_rst || cap_rise) begin
            live_next = init_reg;
        end else if (cfg_wr) begin
            live_next = cfg_wdata & `SCIV_RW_MASK;
        end
    end

    // Both copies come up at the documented defaults on the fundamental reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_reg <= `SCIV_INIT_RST;
            live_reg <= `SCIV_INIT_RST;
            cap_en_reg <= 1'b0;
        end else begin
            init_reg <= init_next;
            live_reg <= live_next;
            cap_en_reg <= cap_en_next;
        end
    end

    assign live_slot_control = live_reg;

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Helper: set once software has written the initial value register.
    logic written_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            written_reg <= 1'b0;
        end else begin
            written_reg <= written_reg || init_wr;
        end
    end

    sequence s_rd_setup;
        psel && !penable && !pwrite && hit(paddr, `SCIV_INIT_OFS);
    endsequence
    sequence s_rd_answer;
        pready && !pslverr && prdata[15:0] == $past(init_reg);
    endsequence
    sequence s_cap_load;
        cap_rise && !init_wr && !part_rst;
    endsequence

    property p_cmd_done_seed;
        s_cap_load |=> live_reg[`SCIV_CMD_DONE_BIT] == $past(init_reg[`SCIV_CMD_DONE_BIT]);
    endproperty
    a_cmd_done_seed: assert property (p_cmd_done_seed) else $error("cmd done seed wrong");

    property p_hotplug_seed;
        s_cap_load |=> live_reg[`SCIV_HOTPLUG_BIT] == $past(init_reg[`SCIV_HOTPLUG_BIT]);
    endproperty
    a_hotplug_seed: assert property (p_hotplug_seed) else $error("hotplug seed wrong");

    property p_attn_dflt;
        !written_reg |-> init_reg[`SCIV_ATTN_LSB +: 2] == `SCIV_ATTN_RST;
    endproperty
    a_attn_dflt: assert property (p_attn_dflt) else $error("attention default wrong");

    property p_pwr_ind_dflt;
        !written_reg |-> init_reg[`SCIV_PWR_IND_LSB +: 2] == `SCIV_PWR_IND_RST;
    endproperty
    a_pwr_ind_dflt: assert property (p_pwr_ind_dflt) else $error("power ind default wrong");

    property p_pwr_ctrl_dflt;
        !written_reg |-> !init_reg[`SCIV_PWR_CTRL_BIT];
    endproperty
    a_pwr_ctrl_dflt: assert property (p_pwr_ctrl_dflt) else $error("power ctrl default wrong");

    property p_link_chg_wr;
        init_wr && pstrb[1] |=> live_reg[`SCIV_LINK_CHG_BIT] == $past(pwdata[`SCIV_LINK_CHG_BIT]);
    endproperty
    a_link_chg_wr: assert property (p_link_chg_wr) else $error("link change not applied");

    property p_wr_now;
        init_wr && pstrb[0] |=> live_reg[7:0] == ($past(pwdata[7:0]) & 8'(`SCIV_RW_MASK));
    endproperty
    a_wr_now: assert property (p_wr_now) else $error("live not updated by write");

    property p_part_keep;
        part_rst && !init_wr |=> $stable(init_reg);
    endproperty
    a_part_keep: assert property (p_part_keep) else $error("init changed by reset");

    property p_part_load;
        part_rst && !init_wr |=> live_reg == $past(init_reg);
    endproperty
    a_part_load: assert property (p_part_load) else $error("live not reloaded");

    property p_rsvd_zero;
        pready |-> (prdata & ~{16'h0000, `SCIV_RW_MASK}) == 32'h0000_0000;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

    property p_rd_init;
        s_rd_setup |=> s_rd_answer ##1 !pready;
    endproperty
    a_rd_init: assert property (p_rd_init) else $error("init read wrong");

endmodule : sciv_slot_init

// ===== verif/slot_ctrl_initial_value_upper_tb.sv
// Self-checking testbench of the slot control initial value bank.
`timescale 1ns/10ps
`include "sciv_regs.svh"
module slot_ctrl_initial_value_upper_tb;
    import sciv_pkg::*;
    // ****************************************
    // Signals and counters
    // ****************************************
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, part_rst, cap_en, cfg_wr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, wd;
    logic [3:0] pstrb, st;
    logic [15:0] cfg_wdata;
    sciv_word_t live_slot_control, init_exp, d;
    int n_mismatch = 0;
    int n_checks = 0;
    int cycles = 0;
    int seed = 32'h6366a8d0;

    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;

    sciv_slot_init i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .part_rst(part_rst), .cap_en(cap_en),
        .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .live_slot_control(live_slot_control));

    // ****************************************
    // Tasks and expectation functions
    // ****************************************
    task end_sim;
        if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One APB transfer; a missing pready is cut short by the cycle ceiling.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w,
                       input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= w; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // Pulse one port-side input (0 config write, 1 partition reset, 2 capability) and check live.
    task automatic pulse(input int which, input sciv_word_t v, input sciv_word_t exp);
        @(posedge pclk);
        if (which == 0) begin
            cfg_wr <= 1'b1;
            cfg_wdata <= v;
        end
        if (which == 1) part_rst <= 1'b1;
        if (which == 2) cap_en <= 1'b1;
        @(posedge pclk);
        cfg_wr <= 1'b0; part_rst <= 1'b0;
        @(posedge pclk);
        cap_en <= 1'b0;
        chk("live_slot_control", {16'h0000, live_slot_control}, {16'h0000, exp});
    endtask : pulse

    // Byte-strobe merge; reserved bits always come back as zero.
    function automatic sciv_word_t merge(sciv_word_t o, logic [31:0] w, logic [3:0] s);
        sciv_word_t n;
        n = o;
        if (s[0]) n[7:0] = w[7:0];
        if (s[1]) n[15:8] = w[15:8];
        return n & `SCIV_RW_MASK;
    endfunction : merge

    // Ceiling far above the few hundred cycles that the sequence needs.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            end_sim();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0000_0000; pstrb = 4'h0; part_rst = 1'b0; cap_en = 1'b0;
        cfg_wr = 1'b0; cfg_wdata = 16'h0000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        init_exp = `SCIV_INIT_RST;
        chk("live_rst", {16'h0000, live_slot_control}, 32'h0000_01C0);
        apb(1'b0, `SCIV_INIT_OFS, 32'h0000_0000, 4'h0);
        chk("init_rst", rd, 32'h0000_01C0);
        // Random writes with all-ones and all-zeros corners first.
        for (int i = 0; i < 24; i++) begin
            wd = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : $random(seed);
            st = (i < 2) ? 4'hF : 4'($random(seed));
            apb(1'b1, `SCIV_INIT_OFS, wd, st);
            init_exp = merge(init_exp, wd, st);
            @(posedge pclk);
            chk("live_wr", {16'h0000, live_slot_control}, {16'h0000, init_exp});
            apb(1'b0, `SCIV_INIT_OFS, 32'h0000_0000, 4'h0);
            chk("init_rd", rd, {16'h0000, init_exp});
        end
        // Live fields diverge, then reload from the stored initial values.
        d = 16'($random(seed));
        pulse(0, d, d & `SCIV_RW_MASK);
        pulse(1, 16'h0000, init_exp);
        apb(1'b0, `SCIV_INIT_OFS, 32'h0000_0000, 4'h0);
        chk("init_part", rd, {16'h0000, init_exp});
        pulse(0, ~init_exp, ~init_exp & `SCIV_RW_MASK);
        pulse(2, 16'h0000, init_exp);
        // Refused accesses leave everything untouched.
        apb(1'b0, 12'h428, 32'h0000_0000, 4'h0);
        chk("unmapped_err", {31'h0, err}, 32'h0000_0001);
        chk("unmapped_rd", rd, 32'h0000_0000);
        apb(1'b1, 12'hC20, ~{16'h0000, init_exp}, 4'hF);
        chk("unmapped_wr_err", {31'h0, err}, 32'h0000_0001);
        apb(1'b1, `SCIV_LIVE_OFS, ~{16'h0000, init_exp}, 4'hF);
        chk("ro_err", {31'h0, err}, 32'h0000_0001);
        apb(1'b0, `SCIV_INIT_OFS, 32'h0000_0000, 4'h0);
        chk("init_kept", rd, {16'h0000, init_exp});
        chk("live_kept", {16'h0000, live_slot_control}, {16'h0000, init_exp});
        // The read-only live copy answers without error and shows the same fields.
        apb(1'b0, `SCIV_LIVE_OFS, 32'h0000_0000, 4'h0);
        chk("live_rd", rd, {16'h0000, init_exp});
        chk("live_rd_err", {31'h0, err}, 32'h0000_0000);
        end_sim();
    end
endmodule : slot_ctrl_initial_value_upper_tb
